// [shared/usc_pkg.sv]
// Constants and types for the serial port status/control block.
// Assumes one AHB-Lite slave port, 32-bit data, one clock domain.
package usc_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_STATUS_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_TX_DATA     = 32'h0000_0004;
  localparam logic [31:0] ADDR_RX_DATA     = 32'h0000_0008;

  // Field positions in the status/control word
  localparam int BIT_TXSEL_HI   = 15;
  localparam int BIT_POLARITY   = 14;
  localparam int BIT_TXSEL_LO   = 13;
  localparam int BIT_UNUSED     = 12;
  localparam int BIT_BREAK      = 11;
  localparam int BIT_TX_ENABLE  = 10;
  localparam int BIT_TX_FULL    = 9;
  localparam int BIT_TX_EMPTY   = 8;
  localparam int BIT_RXSEL_HI   = 7;
  localparam int BIT_RXSEL_LO   = 6;
  localparam int BIT_ADDR_DET   = 5;
  localparam int BIT_RX_IDLE    = 4;
  localparam int BIT_RX_AVAIL   = 0;

  // Frame shape
  localparam int CHAR_BITS       = 8;
  localparam int BREAK_ZERO_BITS = 12;
  localparam int SHIFT_W         = BREAK_ZERO_BITS;

  // Receive buffer and its thresholds
  localparam int RX_DEPTH     = 4;
  localparam int RX_THREE_QTR = 3;

  // Reset values
  localparam logic       CTRL_BIT_RST = 1'b0;
  localparam logic [1:0] CTRL_SEL_RST = 2'b00;
  localparam logic       PIN_RST      = 1'b1;

  // Bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;
  localparam logic       HRESP_OKAY    = 1'b0;

  typedef enum logic [1:0] {
    TXI_EACH  = 2'b00,
    TXI_DONE  = 2'b01,
    TXI_EMPTY = 2'b10,
    TXI_RSVD  = 2'b11
  } usc_txi_mode_t;

  typedef enum logic [1:0] {
    RXI_ANY0 = 2'b00,
    RXI_ANY1 = 2'b01,
    RXI_3QTR = 2'b10,
    RXI_FULL = 2'b11
  } usc_rxi_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } usc_tx_state_t;

endpackage

// [design/usc_top.sv]
// Serial port status/control block: AHB-Lite register slave, transmit
// buffer and shifter with sync break, receive buffer with thresholds.
// Assumes ref_clk at 200 MHz, a receiver outside that delivers whole
// characters, and software that never selects the reserved tx mode.
//
// Overview of operation
// - Mode 10: irq when load empties buffer
// - Mode 01: irq when everything finished sending
// - Mode 00: irq on every shifter load
// - Polarity bit picks idle level, encoder-dependent
// - Break: start, twelve zeros, stop
// - Hardware clears break bit after break frame
// - Enabled transmitter owns and drives pin
// - Disable aborts, flushes buffer, frees pin
// - Full flag set only when buffer full
// - All-empty flag: shifter and buffer empty
// - Rx mode 11: irq at four characters
// - Rx mode 10: irq at three characters
// - Rx mode 0x: irq on every character
// - Bit 12 always reads zero
`timescale 1ns/1ps
module usc_top #(
  parameter int TX_DEPTH = 4,
  parameter int BAUD_DIV = 16
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        infrared_encoder_enable,
  input  wire logic        rx_line_idle,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char,
  output logic             serial_out_pin,
  output logic             serial_out_oe_n,
  output logic             tx_irq,
  output logic             rx_irq
);
  import usc_pkg::*;

  localparam int TPW = $clog2(TX_DEPTH);
  localparam int CW  = $clog2(BAUD_DIV);
  localparam int RPW = $clog2(RX_DEPTH);
  localparam logic [3:0] BRK_LAST  = 4'(BREAK_ZERO_BITS - 1);
  localparam logic [3:0] CHAR_LAST = 4'(CHAR_BITS - 1);

  if (TX_DEPTH < 2 || BAUD_DIV < 2) begin : g_bad_param
    $error("usc_top: TX_DEPTH and BAUD_DIV must be at least 2");
  end

  // Bus slave
  logic          acc;
  logic          wr_ph_q;
  logic          rd_ph_q;
  logic [31:0]   addr_q;
  logic [31:0]   hrdata_q;
  logic [31:0]   rd_val;
  logic          ctrl_wr;
  logic          txd_wr;
  logic          rxd_pop;

  // Control fields
  usc_txi_mode_t txi_mode_q;
  usc_rxi_mode_t rxi_mode_q;
  logic          pol_q;
  logic          brk_q;
  logic          tx_en_q;
  logic          addr_det_q;
  logic [15:0]   status_word;

  // Transmit path
  logic [7:0]     tx_mem [TX_DEPTH];
  logic [TPW-1:0] tx_wr_q;
  logic [TPW-1:0] tx_rd_q;
  logic [TPW:0]   tx_cnt_q;
  logic           tx_push;
  logic           tx_load;
  logic           brk_start;
  logic           tx_buffer_full;
  logic           tx_all_empty;
  usc_tx_state_t  tx_st_q;
  logic [SHIFT_W-1:0] sh_q;
  logic [3:0]     bit_cnt_q;
  logic           is_brk_q;
  logic [CW-1:0]  baud_cnt_q;
  logic           bit_tick;
  logic           frame_done;
  logic           tx_line;
  logic           idle_lvl;
  logic           pin_q;
  logic           tx_irq_q;

  // Receive path
  logic [7:0]     rx_mem [RX_DEPTH];
  logic [RPW-1:0] rx_wr_q;
  logic [RPW-1:0] rx_rd_q;
  logic [RPW:0]   rx_cnt_q;
  logic [RPW:0]   rx_cnt_nx;
  logic           rx_push;
  logic           rx_data_available;
  logic           rx_irq_q;

  // Only whole-word single transfers are taken; others get OKAY, no effect
  assign acc = hsel && hready && (htrans == HTRANS_NONSEQ)
               && (hsize == HSIZE_WORD);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      addr_q  <= 32'h0000_0000;
    end else begin
      wr_ph_q <= acc && hwrite;
      rd_ph_q <= acc && !hwrite;
      if (acc) begin
        addr_q <= haddr;
      end
    end
  end

  // One wait state on reads so that read data leaves a flip-flop
  assign hreadyout = !rd_ph_q;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_q;

  assign ctrl_wr = wr_ph_q && (addr_q == ADDR_STATUS_CTRL);
  assign txd_wr  = wr_ph_q && (addr_q == ADDR_TX_DATA);
  assign rxd_pop = rd_ph_q && (addr_q == ADDR_RX_DATA) && rx_data_available;

  assign status_word = {txi_mode_q[1], pol_q, txi_mode_q[0],
                        1'b0,
                        brk_q, tx_en_q, tx_buffer_full, tx_all_empty,
                        rxi_mode_q, addr_det_q, rx_line_idle, 3'b000,
                        rx_data_available};

  always_comb begin
    rd_val = 32'h0000_0000;
    case (addr_q)
      ADDR_STATUS_CTRL: rd_val = {16'h0000, status_word};
      ADDR_RX_DATA: begin
        if (rx_data_available) begin
          rd_val = {24'h00_0000, rx_mem[rx_rd_q]};
        end
      end
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_ph_q) begin
      hrdata_q <= rd_val;
    end
  end

  // Control register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      txi_mode_q <= usc_txi_mode_t'(CTRL_SEL_RST);
      rxi_mode_q <= usc_rxi_mode_t'(CTRL_SEL_RST);
      pol_q      <= CTRL_BIT_RST;
      tx_en_q    <= CTRL_BIT_RST;
      addr_det_q <= CTRL_BIT_RST;
    end else if (ctrl_wr) begin
      txi_mode_q <= usc_txi_mode_t'({hwdata[BIT_TXSEL_HI],
                                     hwdata[BIT_TXSEL_LO]});
      rxi_mode_q <= usc_rxi_mode_t'({hwdata[BIT_RXSEL_HI],
                                     hwdata[BIT_RXSEL_LO]});
      pol_q      <= hwdata[BIT_POLARITY];
      tx_en_q    <= hwdata[BIT_TX_ENABLE];
      addr_det_q <= hwdata[BIT_ADDR_DET];
    end
  end

  // A software write beats the hardware clear in the same cycle
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      brk_q <= CTRL_BIT_RST;
    end else if (ctrl_wr) begin
      brk_q <= hwdata[BIT_BREAK] && hwdata[BIT_TX_ENABLE];
    end else if (!tx_en_q) begin
      brk_q <= 1'b0;
    end else if (frame_done && is_brk_q) begin
      brk_q <= 1'b0;
    end
  end

  // Transmit buffer
  assign tx_buffer_full = (tx_cnt_q == (TPW+1)'(TX_DEPTH));
  assign tx_all_empty   = (tx_st_q == TX_IDLE) && (tx_cnt_q == '0);
  assign tx_push   = txd_wr && tx_en_q && !tx_buffer_full;
  assign brk_start = tx_en_q && (tx_st_q == TX_IDLE) && brk_q;
  assign tx_load   = tx_en_q && (tx_st_q == TX_IDLE) && !brk_q
                     && (tx_cnt_q != '0);

  always_ff @(posedge ref_clk) begin
    if (tx_push) begin
      tx_mem[tx_wr_q] <= hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_wr_q  <= '0;
      tx_rd_q  <= '0;
      tx_cnt_q <= '0;
    end else if (!tx_en_q) begin
      tx_wr_q  <= '0;
      tx_rd_q  <= '0;
      tx_cnt_q <= '0;
    end else begin
      if (tx_push) begin
        tx_wr_q <= (tx_wr_q == TPW'(TX_DEPTH - 1)) ? '0 : tx_wr_q + 1'b1;
      end
      if (tx_load) begin
        tx_rd_q <= (tx_rd_q == TPW'(TX_DEPTH - 1)) ? '0 : tx_rd_q + 1'b1;
      end
      tx_cnt_q <= tx_cnt_q + (TPW+1)'(tx_push) - (TPW+1)'(tx_load);
    end
  end

  // Bit-rate enable; restarts with each frame so the start bit is full
  assign bit_tick   = (tx_st_q != TX_IDLE) && (baud_cnt_q == CW'(BAUD_DIV-1));
  assign frame_done = (tx_st_q == TX_STOP) && bit_tick;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_cnt_q <= '0;
    end else if (tx_st_q == TX_IDLE || bit_tick) begin
      baud_cnt_q <= '0;
    end else begin
      baud_cnt_q <= baud_cnt_q + 1'b1;
    end
  end

  // Shifter; a break is a frame of zeros thirteen bits long, start bit included
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_st_q   <= TX_IDLE;
      sh_q      <= '0;
      bit_cnt_q <= 4'h0;
      is_brk_q  <= 1'b0;
    end else if (!tx_en_q) begin
      tx_st_q  <= TX_IDLE;
      is_brk_q <= 1'b0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (brk_start) begin
            tx_st_q  <= TX_START;
            sh_q     <= '0;
            is_brk_q <= 1'b1;
          end else if (tx_load) begin
            tx_st_q  <= TX_START;
            sh_q     <= SHIFT_W'(tx_mem[tx_rd_q]);
            is_brk_q <= 1'b0;
          end
        end
        TX_START: begin
          if (bit_tick) begin
            tx_st_q   <= TX_DATA;
            bit_cnt_q <= 4'h0;
          end
        end
        TX_DATA: begin
          if (bit_tick) begin
            sh_q <= sh_q >> 1;
            if (bit_cnt_q == (is_brk_q ? BRK_LAST : CHAR_LAST)) begin
              tx_st_q <= TX_STOP;
            end else begin
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (bit_tick) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  assign tx_line  = (tx_st_q == TX_START) ? 1'b0 :
                    (tx_st_q == TX_DATA)  ? sh_q[0] : 1'b1;
  // Encoder on: set means idle high; encoder off: set means idle low
  assign idle_lvl = infrared_encoder_enable ? pol_q : !pol_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q <= PIN_RST;
    end else begin
      pin_q <= idle_lvl ? tx_line : !tx_line;
    end
  end

  assign serial_out_pin  = pin_q;
  assign serial_out_oe_n = !tx_en_q;

  // Transmit event pulse; the reserved mode gives none
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_irq_q <= 1'b0;
    end else begin
      case (txi_mode_q)
        TXI_EACH:  tx_irq_q <= tx_load;
        TXI_EMPTY: tx_irq_q <= tx_load && (tx_cnt_q == (TPW+1)'(1))
                               && !tx_push;
        TXI_DONE:  tx_irq_q <= frame_done && (tx_cnt_q == '0) && !tx_push
                               && (is_brk_q || !brk_q);
        default:   tx_irq_q <= 1'b0;
      endcase
    end
  end
  assign tx_irq = tx_irq_q;

  // Receive buffer; a character arriving while full is dropped
  assign rx_data_available = (rx_cnt_q != '0);
  assign rx_push   = rx_char_valid && (rx_cnt_q != (RPW+1)'(RX_DEPTH));
  assign rx_cnt_nx = rx_cnt_q + (RPW+1)'(rx_push) - (RPW+1)'(rxd_pop);

  always_ff @(posedge ref_clk) begin
    if (rx_push) begin
      rx_mem[rx_wr_q] <= rx_char;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_wr_q  <= '0;
      rx_rd_q  <= '0;
      rx_cnt_q <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_q <= rx_wr_q + 1'b1;
      end
      if (rxd_pop) begin
        rx_rd_q <= rx_rd_q + 1'b1;
      end
      rx_cnt_q <= rx_cnt_nx;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_irq_q <= 1'b0;
    end else begin
      case (rxi_mode_q)
        RXI_FULL: rx_irq_q <= rx_push
                              && (rx_cnt_nx == (RPW+1)'(RX_DEPTH));
        RXI_3QTR: rx_irq_q <= rx_push
                              && (rx_cnt_nx == (RPW+1)'(RX_THREE_QTR));
        default:  rx_irq_q <= rx_push;
      endcase
    end
  end
  assign rx_irq = rx_irq_q;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  AST_TX_EMPTIED: assert property (
    txi_mode_q == TXI_EMPTY && tx_load && tx_cnt_q == 1 && !tx_push
    |=> tx_irq ##1 !tx_irq)
    else $error("tx irq missing when buffer emptied");
  AST_TX_DONE: assert property (
    $past(txi_mode_q) == TXI_DONE && tx_irq |-> $past(frame_done)
    && tx_all_empty)
    else $error("tx done irq without finished transmission");
  AST_TX_EACH: assert property (
    txi_mode_q == TXI_EACH && $past(txi_mode_q) == TXI_EACH
    |-> tx_irq == $past(tx_load))
    else $error("tx irq does not match shifter load");
  AST_IDLE_LEVEL: assert property (
    tx_st_q == TX_IDLE && $stable(pol_q)
    && $stable(infrared_encoder_enable)
    |=> serial_out_pin == $past(idle_lvl))
    else $error("idle level wrong for polarity setting");
  AST_BREAK_ZEROS: assert property (
    is_brk_q && tx_st_q == TX_DATA |-> tx_line == 1'b0
    && bit_cnt_q <= BRK_LAST)
    else $error("break frame carries a one or too many bits");
  AST_BREAK_CLEAR: assert property (
    frame_done && is_brk_q && !ctrl_wr |=> !brk_q && tx_st_q == TX_IDLE)
    else $error("break bit not cleared after break frame");
  AST_PIN_OWNED: assert property (
    tx_st_q != TX_IDLE |-> !serial_out_oe_n || $fell(tx_en_q))
    else $error("pin released while frame in flight");
  AST_DISABLE_ABORT: assert property (
    $fell(tx_en_q) |=> tx_cnt_q == 0 && tx_st_q == TX_IDLE
    && serial_out_oe_n)
    else $error("disable did not abort and flush");
  AST_FULL_FLAG: assert property (
    tx_push && !tx_load && tx_cnt_q == TX_DEPTH - 1 |=> tx_buffer_full
    && status_word[BIT_TX_FULL])
    else $error("full flag missing after last slot filled");
  AST_ALL_EMPTY: assert property (
    status_word[BIT_TX_EMPTY] |-> tx_st_q == TX_IDLE && tx_cnt_q == 0)
    else $error("all-empty flag set while data pending");
  AST_RX_FULL: assert property (
    rxi_mode_q == RXI_FULL && rx_push && !rxd_pop && rx_cnt_q == 3
    |=> rx_irq && rx_cnt_q == 4)
    else $error("rx full irq missing");
  AST_RX_3QTR: assert property (
    $past(rxi_mode_q) == RXI_3QTR && rx_irq |-> rx_cnt_q == 3
    && $past(rx_push))
    else $error("rx three-quarter irq at wrong fill");
  AST_RX_ANY: assert property (
    !rxi_mode_q[1] && $past(!rxi_mode_q[1])
    |-> rx_irq == $past(rx_push))
    else $error("rx irq does not follow each character");
  AST_BIT12_ZERO: assert property (
    rd_ph_q && addr_q == ADDR_STATUS_CTRL |=> hrdata[BIT_UNUSED] == 1'b0
    && hreadyout)
    else $error("unimplemented bit reads as one");
  AST_BREAK_CANCEL: assert property (
    !tx_en_q && !ctrl_wr |=> !brk_q && !is_brk_q)
    else $error("break pending while transmitter disabled");

  COV_BREAK: cover property (frame_done && is_brk_q);
  COV_RX_FULL: cover property (rxi_mode_q == RXI_FULL && rx_irq);
  COV_TX_EMPTIED: cover property (txi_mode_q == TXI_EMPTY && tx_irq);
  COV_READ: cover property (rd_ph_q ##1 hreadyout);

endmodule

// [tb/usc_far_end.sv]
// Far-end model: a remote receiver that decodes the serial line and a
// remote transmitter that hands whole characters to the receive side.
// Assumes an idle-high line and BD clock cycles for each bit.
`timescale 1ns/1ps
module usc_far_end #(
  parameter int BD = 4
) (
  input  wire logic  clk,
  input  wire logic  pin,
  input  wire logic  oe_n,
  output logic       rx_line_idle,
  output logic       rx_char_valid,
  output logic [7:0] rx_char
);
  logic [7:0] got [$];
  int         low_cnt = 0;
  int         last_low = 0;
  int         n_low_runs = 0;

  initial begin
    rx_line_idle  = 1'b1;
    rx_char_valid = 1'b0;
    rx_char       = 8'h00;
  end

  // Length of every low run, so a break frame can be measured
  always @(posedge clk) begin
    if (pin === 1'b0)
      low_cnt <= low_cnt + 1;
    else if (low_cnt != 0) begin
      last_low   <= low_cnt;
      n_low_runs <= n_low_runs + 1;
      low_cnt    <= 0;
    end
  end

  // Mid-bit sampling; a frame with a low stop bit (break) is not kept
  initial forever begin : decode
    logic [7:0] d;
    @(negedge pin);
    repeat (BD / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BD) @(posedge clk);
      d[i] = pin;
    end
    repeat (BD) @(posedge clk);
    if (pin === 1'b1 && oe_n === 1'b0)
      got.push_back(d);
  end

  // Stale data is never left on the lines between characters
  task automatic send(input logic [7:0] c);
    @(posedge clk);
    rx_char_valid <= 1'b1;
    rx_char       <= c;
    @(posedge clk);
    rx_char_valid <= 1'b0;
    rx_char       <= ~c;
  endtask
endmodule

// [tb/usc_top_tb_top.sv]
// Self-checking bench for the serial port status/control block.
// Assumes one AHB-Lite slave whose hreadyout is the bus hready.
`timescale 1ns/1ps
module usc_top_tb_top;
  import usc_pkg::*;
  localparam int          BD  = 4;
  localparam logic [31:0] EN  = 32'h0000_0400;
  localparam logic [31:0] BRK = 32'h0000_0800;
  logic        ref_clk, reset_n, hsel, hwrite, ir_en, hreadyout, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic        pin, oe_n, tx_irq, rx_irq, rx_idle, rx_vld;
  logic [7:0]  rx_chr;
  int          n_errors, num_checks, n_txi, n_rxi;

  usc_top #(.TX_DEPTH(4), .BAUD_DIV(BD)) uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .infrared_encoder_enable(ir_en),
    .rx_line_idle(rx_idle), .rx_char_valid(rx_vld), .rx_char(rx_chr),
    .serial_out_pin(pin), .serial_out_oe_n(oe_n), .tx_irq(tx_irq),
    .rx_irq(rx_irq));

  usc_far_end #(.BD(BD)) fe (
    .clk(ref_clk), .pin(pin), .oe_n(oe_n), .rx_line_idle(rx_idle),
    .rx_char_valid(rx_vld), .rx_char(rx_chr));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (tx_irq === 1'b1)
      n_txi++;
    if (rx_irq === 1'b1)
      n_rxi++;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr  <= a;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h0, v);
  endtask

  task automatic t_reset;
    logic [31:0] v;
    rd(ADDR_STATUS_CTRL, v);
    chk("status at reset", v, 32'h0000_0110);
    chk("hresp okay", 32'(hresp), 32'(HRESP_OKAY));
    chk("pin free at reset", 32'(oe_n), 32'h1);
    rd(32'h0000_000c, v);
    chk("unmapped read", v, 32'h0);
  endtask

  // Mode 11 is never selected by software
  task automatic t_tx_modes;
    logic [31:0] v;
    logic [1:0]  md [3] = '{2'b00, 2'b01, 2'b10};
    int          ex [3] = '{3, 1, 2};
    logic [7:0]  ch [3] = '{8'ha5, 8'h3c, 8'h81};
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_STATUS_CTRL, EN | {md[m][1], 1'b0, md[m][0], 13'h0});
      fe.got.delete();
      n_txi = 0;
      for (int i = 0; i < 3; i++)
        wr(ADDR_TX_DATA, 32'(ch[i]));
      rd(ADDR_STATUS_CTRL, v);
      chk("tx_all_empty busy", 32'(v[BIT_TX_EMPTY]), 32'h0);
      for (int i = 0; i < 400 && fe.got.size() < 3; i++)
        @(posedge ref_clk);
      repeat (2 * BD) @(posedge ref_clk);
      chk("tx irq count", 32'(n_txi), 32'(ex[m]));
      for (int i = 0; i < 3; i++)
        chk("tx char", 32'(fe.got[i]), 32'(ch[i]));
      rd(ADDR_STATUS_CTRL, v);
      chk("tx_all_empty idle", 32'(v[BIT_TX_EMPTY]), 32'h1);
    end
  endtask

  task automatic t_full;
    logic [31:0] v;
    wr(ADDR_STATUS_CTRL, EN);
    for (int i = 0; i < 4; i++)
      wr(ADDR_TX_DATA, 32'h0000_0011);
    rd(ADDR_STATUS_CTRL, v);
    chk("full with three queued", 32'(v[BIT_TX_FULL]), 32'h0);
    wr(ADDR_TX_DATA, 32'h0000_0022);
    rd(ADDR_STATUS_CTRL, v);
    chk("full with four queued", 32'(v[BIT_TX_FULL]), 32'h1);
    wr(ADDR_STATUS_CTRL, 32'h0);
    rd(ADDR_STATUS_CTRL, v);
    chk("status after abort", v, 32'h0000_0110);
    chk("pin released", 32'(oe_n), 32'h1);
    repeat (12 * BD) @(posedge ref_clk);
    fe.got.delete();
    wr(ADDR_STATUS_CTRL, EN);
    repeat (12 * BD) @(posedge ref_clk);
    chk("frames after flush", 32'(fe.got.size()), 32'h0);
  endtask

  task automatic t_break;
    logic [31:0] v;
    int          runs;
    runs = fe.n_low_runs;
    wr(ADDR_STATUS_CTRL, EN | BRK);
    for (int i = 0; i < 400 && fe.n_low_runs == runs; i++)
      @(posedge ref_clk);
    chk("break low span", 32'(fe.last_low), 32'(13 * BD));
    repeat (2 * BD) @(posedge ref_clk);
    rd(ADDR_STATUS_CTRL, v);
    chk("break bit cleared", v, 32'h0000_0510);
    wr(ADDR_STATUS_CTRL, EN | BRK);
    repeat (BD) @(posedge ref_clk);
    wr(ADDR_STATUS_CTRL, BRK);
    rd(ADDR_STATUS_CTRL, v);
    chk("break cancelled", v, 32'h0000_0110);
    repeat (4 * BD) @(posedge ref_clk);
    runs = fe.n_low_runs;
    wr(ADDR_STATUS_CTRL, EN);
    repeat (16 * BD) @(posedge ref_clk);
    chk("no break after enable", 32'(fe.n_low_runs), 32'(runs));
  endtask

  task automatic t_rx;
    logic [31:0] v;
    int          e3 [4] = '{3, 3, 1, 0};
    int          e4 [4] = '{4, 4, 1, 1};
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_STATUS_CTRL, 32'(m) << BIT_RXSEL_LO);
      n_rxi = 0;
      for (int i = 0; i < 3; i++)
        fe.send(8'(32'h40 + i));
      repeat (3) @(posedge ref_clk);
      chk("rx irq at three", 32'(n_rxi), 32'(e3[m]));
      fe.send(8'h43);
      repeat (3) @(posedge ref_clk);
      chk("rx irq at four", 32'(n_rxi), 32'(e4[m]));
      rd(ADDR_STATUS_CTRL, v);
      chk("rx data available", 32'(v[BIT_RX_AVAIL]), 32'h1);
      for (int i = 0; i < 4; i++) begin
        rd(ADDR_RX_DATA, v);
        chk("rx char", v, 32'h40 + 32'(i));
      end
      rd(ADDR_STATUS_CTRL, v);
      chk("rx drained", 32'(v[BIT_RX_AVAIL]), 32'h0);
    end
  endtask

  task automatic t_pol;
    logic [31:0] v;
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      ir_en <= k[1];
      wr(ADDR_STATUS_CTRL, EN | 32'h1020 | (32'(k[0]) << BIT_POLARITY));
      rd(ADDR_STATUS_CTRL, v);
      chk("bit 12", 32'(v[BIT_UNUSED]), 32'h0);
      chk("address detect", 32'(v[BIT_ADDR_DET]), 32'h1);
      repeat (4) @(posedge ref_clk);
      chk("idle level", 32'(pin), 32'(k[1] ? k[0] : !k[0]));
      chk("pin owned", 32'(oe_n), 32'h0);
    end
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    hsel    = 1'b0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    haddr   = 32'h0;
    hwdata  = 32'h0;
    ir_en   = 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset;
    t_tx_modes;
    t_full;
    t_break;
    t_rx;
    t_pol;
    close_out;
  end

  // A hang counts as a mismatch and ends the run the normal way
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    close_out;
  end
endmodule
